// >>> include/cpm_pkg.sv
package cpm_pkg;

  // ----------------------------------------------------------------
  // management access
  // ----------------------------------------------------------------
  localparam logic [1:0]  MGMT_CTRL_ID = 2'h0;
  localparam logic [4:0]  REG_C45_DATA = 5'h0E;
  localparam logic [4:0]  REG_PAGE     = 5'h1F;
  localparam logic [4:0]  REG_EXT_LO   = 5'h10;
  localparam logic [15:0] PAGE_EXT1    = 16'h0001;
  localparam logic [15:0] PAGE_EXT2    = 16'h0002;
  localparam logic [15:0] PAGE_GP      = 16'h0010;

  typedef enum logic [1:0] {
    CPM_SP_STD,
    CPM_SP_EXT1,
    CPM_SP_EXT2,
    CPM_SP_GP
  } cpm_space_e;

  // ----------------------------------------------------------------
  // keys: {space, register address}
  // ----------------------------------------------------------------
  localparam logic [6:0] K_CTRL = 7'h00;
  localparam logic [6:0] K_STAT = 7'h01;
  localparam logic [6:0] K_C45C = 7'h0D;
  localparam logic [6:0] K_C45D = 7'h0E;
  localparam logic [6:0] K_BYP  = 7'h12;
  localparam logic [6:0] K_EXTC = 7'h16;
  localparam logic [6:0] K_IMSK = 7'h19;
  localparam logic [6:0] K_ISTA = 7'h1A;
  localparam logic [6:0] K_AUX  = 7'h1C;
  localparam logic [6:0] K_EXT3 = 7'h34;
  localparam logic [6:0] K_MODE = 7'h37;
  localparam logic [6:0] K_EEE  = 7'h51;
  localparam logic [6:0] K_WA0  = 7'h55;
  localparam logic [6:0] K_WA1  = 7'h56;
  localparam logic [6:0] K_WA2  = 7'h57;
  localparam logic [6:0] K_WCFG = 7'h5B;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int B_SOFT_RST  = 15;
  localparam int B_SPD_LSB   = 13;
  localparam int B_NEG_EN    = 12;
  localparam int B_DUPLEX    = 8;
  localparam int B_SPD_MSB   = 6;
  localparam int B_LINK      = 2;
  localparam int B_NEG_DONE  = 5;
  localparam int B_ALL_WR    = 0;
  localparam int B_RETAIN    = 1;
  localparam int B_FRX_DIS   = 7;
  localparam int B_XOVER_DIS = 5;
  localparam int B_POL_DIS   = 4;
  localparam int B_FB_EN     = 4;
  localparam int B_FB_CFG    = 2;
  localparam int B_FB_STAT   = 1;
  localparam int B_MAN_PAIR  = 2;
  localparam int B_GIG_TEST  = 5;
  localparam int B_LOW_AMP   = 4;
  localparam int B_WAKE      = 6;
  localparam int B_AUX_MDIX  = 13;
  localparam int B_AUX_CDSW  = 12;
  localparam int B_AUX_POL   = 8;
  localparam int B_AUX_DUP   = 5;
  localparam int B_AUX_SPD   = 3;
  localparam int B_C45_FUNC  = 14;

  // ----------------------------------------------------------------
  // values after reset and field codes
  // ----------------------------------------------------------------
  localparam logic       RST_NEG_EN  = 1'b1;
  localparam logic       RST_SPD_MSB = 1'b1;
  localparam logic       RST_SPD_LSB = 1'b0;
  localparam logic       RST_DUPLEX  = 1'b1;
  localparam logic       RST_RETAIN  = 1'b1;
  localparam logic [1:0] RST_FB_CFG  = 2'h1;
  localparam logic [3:0] FB_BASE     = 4'h2;
  localparam logic [1:0] SPD_10      = 2'h0;
  localparam logic [1:0] SPD_1000    = 2'h2;
  localparam logic [1:0] PAIR_MDI    = 2'h2;
  localparam logic [1:0] PAIR_MDIX   = 2'h3;

  // ----------------------------------------------------------------
  // line side carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       link_up;
    logic       partner_neg;
    logic       partner_gig;
    logic       gig_fail;
    logic [1:0] pd_speed;
    logic [1:0] res_speed;
    logic       res_duplex;
    logic       res_master;
    logic       mdix_seen;
    logic       cd_swap_seen;
    logic [3:0] pol_inv;
    logic       tx_idle;
    logic       wake_pkt;
  } cpm_line_stat_s;

  typedef struct packed {
    logic       neg_run;
    logic [1:0] speed;
    logic       duplex;
    logic       master;
    logic       adv_gig;
    logic       gig_test;
    logic       mdix;
    logic       cd_swap;
    logic       pol_fix_en;
    logic       lpi_en;
    logic       low_amp_10m;
    logic       wake_irq;
  } cpm_line_cfg_s;

endpackage

// >>> src/cpm_mem.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// word store with registered read
// ------------------------------------------------------------------
module cpm_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  input  wire logic          ref_clk_i,
  input  wire logic          we_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [2**AW];

  // write port
  always_ff @(posedge ref_clk_i)
  begin
    if (we_i)
    begin
      mem[addr_i] <= wdata_i;
    end
  end

  // read data register
  always_ff @(posedge ref_clk_i)
  begin
    if (re_i)
    begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule // cpm_mem

// >>> src/cpm_top.sv
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module cpm_top import cpm_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter int         FB_CW    = 4
) (
  input  wire logic           ref_clk_i,
  input  wire logic           rstn_i,
  input  wire logic [1:0]     mgmt_ctrl_id_i,
  input  wire logic [4:0]     mgmt_phy_addr_i,
  input  wire logic [4:0]     mgmt_reg_addr_i,
  input  wire logic [15:0]    mgmt_wdata_i,
  input  wire logic           mgmt_we_i,
  input  wire logic           mgmt_re_i,
  output logic      [15:0]    mgmt_rdata_o,
  output logic                mgmt_rack_o,
  input  wire cpm_line_stat_s line_stat_i,
  output cpm_line_cfg_s       line_cfg_o,
  output logic      [47:0]    wake_station_address_o
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // space that a register address falls in under a page
  function automatic cpm_space_e cpm_space(logic [15:0] pg, logic [4:0] ra);
    cpm_space_e s;
    s = CPM_SP_STD;
    if (pg == PAGE_GP)
      s = CPM_SP_GP;
    else if (pg == PAGE_EXT1 && ra >= REG_EXT_LO)
      s = CPM_SP_EXT1;
    else if (pg == PAGE_EXT2 && ra >= REG_EXT_LO)
      s = CPM_SP_EXT2;
    return s;
  endfunction

  // keys backed by dedicated fields rather than the store
  function automatic logic cpm_is_field(logic [6:0] k);
    return k inside {K_CTRL, K_STAT, K_C45C, K_C45D, K_BYP, K_EXTC,
                     K_IMSK, K_ISTA, K_AUX, K_EXT3, K_MODE, K_EEE,
                     K_WA0, K_WA1, K_WA2, K_WCFG};
  endfunction

  // store words kept across a soft reset: general-purpose page
  function automatic logic cpm_retained(logic [7:0] idx);
    return !idx[7] && (idx[6:5] == 2'(CPM_SP_GP));
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic              neg_en_reg, spd_msb_reg, spd_lsb_reg, duplex_reg;
  logic              soft_rst_reg;
  logic              all_wr_reg, retain_reg;
  logic              frx_dis_reg, xover_dis_reg, pol_dis_reg;
  logic              fb_en_reg, downshift_reg;
  logic [1:0]        fb_cfg_reg, man_pair_reg;
  logic [FB_CW-1:0]  fail_cnt_reg;
  logic              gig_test_reg, low_amp_reg;
  logic              wake_mask_reg, wake_pend_reg;
  logic [15:0]       page_reg, c45_ctrl_reg, c45_addr_reg, wake_cfg_reg;
  logic [15:0]       wa_reg [3];
  logic [255:0]      valid_reg;
  logic              rd_ok_reg, rd_mem_reg, rd_vld_reg;
  logic [15:0]       rd_fld_reg, mem_q, fld_val;
  cpm_line_cfg_s     cfg_next;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic       id_ok, addr_ok, wr_ok, rd_ok, is_page, c45_data;
  logic       sticky_clr, mem_we, mem_acc;
  logic [6:0] key;
  logic [7:0] mem_idx;
  logic [15:0] wd;

  assign id_ok   = (mgmt_ctrl_id_i == MGMT_CTRL_ID);
  assign addr_ok = (mgmt_phy_addr_i == PHY_ADDR);
  assign wr_ok   = mgmt_we_i && id_ok && (addr_ok || all_wr_reg);
  assign rd_ok   = mgmt_re_i && id_ok && addr_ok;
  assign is_page = (mgmt_reg_addr_i == REG_PAGE);
  assign key     = {2'(cpm_space(page_reg, mgmt_reg_addr_i)),
                    mgmt_reg_addr_i};
  assign c45_data = (key == K_C45D) && (c45_ctrl_reg[B_C45_FUNC +: 2] != 2'h0);
  assign mem_acc  = !is_page && (c45_data || !cpm_is_field(key));
  assign mem_idx  = c45_data ? {1'b1, c45_addr_reg[6:0]}
                             : {1'b0, key};
  assign mem_we   = wr_ok && mem_acc && !soft_rst_reg;
  assign sticky_clr = soft_rst_reg && !retain_reg;
  assign wd = mgmt_wdata_i;

  // write strobe for one key
  function automatic logic wr_hit(logic [6:0] k);
    return wr_ok && !is_page && (key == k);
  endfunction

  // ----------------------------------------------------------------
  // page, control and soft reset
  // ----------------------------------------------------------------
  // page select, kept across a soft reset like other retained fields
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i || sticky_clr)
      page_reg <= 16'h0000;
    else if (wr_ok && is_page)
      page_reg <= wd;
  end

  // soft reset strobe, self clearing after one cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      soft_rst_reg <= 1'b0;
    else
      soft_rst_reg <= wr_hit(K_CTRL) && wd[B_SOFT_RST] && !soft_rst_reg;
  end

  // negotiation, speed and duplex control
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i || soft_rst_reg)
    begin
      neg_en_reg  <= RST_NEG_EN;
      spd_msb_reg <= RST_SPD_MSB;
      spd_lsb_reg <= RST_SPD_LSB;
      duplex_reg  <= RST_DUPLEX;
    end
    else if (wr_hit(K_CTRL))
    begin
      neg_en_reg  <= wd[B_NEG_EN];
      spd_msb_reg <= wd[B_SPD_MSB];
      spd_lsb_reg <= wd[B_SPD_LSB];
      duplex_reg  <= wd[B_DUPLEX];
    end
  end

  // retained extended control
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i || sticky_clr)
    begin
      all_wr_reg <= 1'b0;
      retain_reg <= RST_RETAIN;
    end
    else if (wr_hit(K_EXTC) && !soft_rst_reg)
    begin
      all_wr_reg <= wd[B_ALL_WR];
      retain_reg <= wd[B_RETAIN];
    end
  end

  // ----------------------------------------------------------------
  // plain configuration fields
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i || soft_rst_reg)
    begin
      frx_dis_reg   <= 1'b0;
      xover_dis_reg <= 1'b0;
      pol_dis_reg   <= 1'b0;
      fb_en_reg     <= 1'b0;
      fb_cfg_reg    <= RST_FB_CFG;
      man_pair_reg  <= 2'h0;
      gig_test_reg  <= 1'b0;
      low_amp_reg   <= 1'b0;
      wake_mask_reg <= 1'b0;
      wake_cfg_reg  <= 16'h0000;
      c45_ctrl_reg  <= 16'h0000;
      c45_addr_reg  <= 16'h0000;
      for (int i = 0; i < 3; i++)
        wa_reg[i] <= 16'h0000;
    end
    else
    begin
      if (wr_hit(K_BYP))
      begin
        frx_dis_reg   <= wd[B_FRX_DIS];
        xover_dis_reg <= wd[B_XOVER_DIS];
        pol_dis_reg   <= wd[B_POL_DIS];
      end
      if (wr_hit(K_EXT3))
      begin
        fb_en_reg  <= wd[B_FB_EN];
        fb_cfg_reg <= wd[B_FB_CFG +: 2];
      end
      if (wr_hit(K_MODE))
        man_pair_reg <= wd[B_MAN_PAIR +: 2];
      if (wr_hit(K_EEE))
      begin
        gig_test_reg <= wd[B_GIG_TEST];
        low_amp_reg  <= wd[B_LOW_AMP];
      end
      if (wr_hit(K_IMSK))
        wake_mask_reg <= wd[B_WAKE];
      if (wr_hit(K_WCFG))
        wake_cfg_reg <= wd;
      if (wr_hit(K_C45C))
        c45_ctrl_reg <= wd;
      if (wr_hit(K_C45D) && !c45_data)
        c45_addr_reg <= wd;
      if (wr_hit(K_WA0))
        wa_reg[0] <= wd;
      if (wr_hit(K_WA1))
        wa_reg[1] <= wd;
      if (wr_hit(K_WA2))
        wa_reg[2] <= wd;
    end
  end

  // ----------------------------------------------------------------
  // store validity: unwritten words read as their zero default
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      valid_reg <= '0;
    else if (soft_rst_reg)
    begin
      for (int i = 0; i < 256; i++)
        if (!cpm_retained(8'(i)) || !retain_reg)
          valid_reg[i] <= 1'b0;
    end
    else if (mem_we)
      valid_reg[mem_idx] <= 1'b1;
  end

  cpm_mem #(
    .AW (8),
    .DW (16)
  ) u_mem (
    .ref_clk_i (ref_clk_i),
    .we_i      (mem_we),
    .re_i      (rd_ok),
    .addr_i    (mem_idx),
    .wdata_i   (wd),
    .rdata_o   (mem_q)
  );

  // ----------------------------------------------------------------
  // line behaviour
  // ----------------------------------------------------------------
  logic       forced_gig, forced_lo, test_gig, neg_run, auto_ok;
  logic [1:0] cur_speed;
  logic [FB_CW-1:0] fb_limit;

  assign forced_gig = !neg_en_reg && spd_msb_reg && !spd_lsb_reg;
  assign test_gig   = !neg_en_reg && gig_test_reg && spd_lsb_reg
                      && !spd_msb_reg;
  assign neg_run    = neg_en_reg || (forced_gig && !test_gig);
  assign forced_lo  = !neg_run && !test_gig;
  assign auto_ok    = !xover_dis_reg && !(forced_lo && frx_dis_reg);
  assign fb_limit   = FB_CW'(FB_BASE) + FB_CW'(fb_cfg_reg);

  // resolved speed and duplex
  always_comb
  begin
    cfg_next = '0;
    if (test_gig)
      cur_speed = SPD_1000;
    else if (!neg_run)
      cur_speed = {spd_msb_reg, spd_lsb_reg};
    else if (line_stat_i.partner_neg)
      cur_speed = line_stat_i.res_speed;
    else
      cur_speed = line_stat_i.pd_speed;
    cfg_next.neg_run  = neg_run;
    cfg_next.speed    = cur_speed;
    cfg_next.duplex   = neg_run ? line_stat_i.res_duplex : duplex_reg;
    cfg_next.master   = neg_run && line_stat_i.res_master;
    cfg_next.adv_gig  = !downshift_reg;
    cfg_next.gig_test = test_gig;
    unique case (man_pair_reg)
      PAIR_MDI:  cfg_next.mdix = 1'b0;
      PAIR_MDIX: cfg_next.mdix = 1'b1;
      default:
      begin
        cfg_next.mdix    = auto_ok && line_stat_i.mdix_seen;
        cfg_next.cd_swap = auto_ok && line_stat_i.cd_swap_seen;
      end
    endcase
    cfg_next.pol_fix_en  = !pol_dis_reg;
    cfg_next.lpi_en      = line_stat_i.link_up && line_stat_i.tx_idle
                           && (cur_speed != SPD_10);
    cfg_next.low_amp_10m = low_amp_reg && (cur_speed == SPD_10);
    cfg_next.wake_irq    = wake_pend_reg && wake_mask_reg;
  end

  // registered line configuration
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      line_cfg_o <= '0;
    else
      line_cfg_o <= cfg_next;
  end

  // gigabit failure counting and downshift
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i || soft_rst_reg || !fb_en_reg
        || line_stat_i.partner_gig)
    begin
      fail_cnt_reg  <= '0;
      downshift_reg <= 1'b0;
    end
    else if (neg_run && line_stat_i.gig_fail && !downshift_reg)
    begin
      fail_cnt_reg  <= fail_cnt_reg + FB_CW'(1);
      downshift_reg <= (fail_cnt_reg + FB_CW'(1)) >= fb_limit;
    end
  end

  // wake pending: set wins over clear on read
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i || soft_rst_reg)
      wake_pend_reg <= 1'b0;
    else if (line_stat_i.wake_pkt && wake_mask_reg && line_stat_i.link_up)
      wake_pend_reg <= 1'b1;
    else if (rd_ok && !is_page && key == K_ISTA)
      wake_pend_reg <= 1'b0;
  end

  assign wake_station_address_o = {wa_reg[2], wa_reg[1], wa_reg[0]};

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb
  begin
    fld_val = 16'h0000;
    if (is_page)
      fld_val = page_reg;
    else
      unique case (key)
        K_CTRL:
        begin
          fld_val[B_SOFT_RST] = soft_rst_reg;
          fld_val[B_NEG_EN]   = neg_en_reg;
          fld_val[B_SPD_MSB]  = spd_msb_reg;
          fld_val[B_SPD_LSB]  = spd_lsb_reg;
          fld_val[B_DUPLEX]   = duplex_reg;
        end
        K_STAT:
        begin
          fld_val[B_LINK]     = line_stat_i.link_up;
          fld_val[B_NEG_DONE] = line_stat_i.link_up && neg_run;
        end
        K_EXTC:
        begin
          fld_val[B_ALL_WR] = all_wr_reg;
          fld_val[B_RETAIN] = retain_reg;
        end
        K_BYP:
        begin
          fld_val[B_FRX_DIS]   = frx_dis_reg;
          fld_val[B_XOVER_DIS] = xover_dis_reg;
          fld_val[B_POL_DIS]   = pol_dis_reg;
        end
        K_AUX:
        begin
          fld_val[B_AUX_MDIX]     = line_cfg_o.mdix;
          fld_val[B_AUX_CDSW]     = line_cfg_o.cd_swap;
          fld_val[B_AUX_POL +: 4] = line_cfg_o.pol_fix_en
                                    ? line_stat_i.pol_inv : 4'h0;
          fld_val[B_AUX_DUP]      = line_cfg_o.duplex;
          fld_val[B_AUX_SPD +: 2] = line_cfg_o.speed;
        end
        K_EXT3:
        begin
          fld_val[B_FB_EN]       = fb_en_reg;
          fld_val[B_FB_CFG +: 2] = fb_cfg_reg;
          fld_val[B_FB_STAT]     = downshift_reg;
        end
        K_MODE:  fld_val[B_MAN_PAIR +: 2] = man_pair_reg;
        K_EEE:
        begin
          fld_val[B_GIG_TEST] = gig_test_reg;
          fld_val[B_LOW_AMP]  = low_amp_reg;
        end
        K_IMSK:  fld_val[B_WAKE] = wake_mask_reg;
        K_ISTA:  fld_val[B_WAKE] = wake_pend_reg;
        K_WCFG:  fld_val = wake_cfg_reg;
        K_C45C:  fld_val = c45_ctrl_reg;
        K_C45D:  fld_val = c45_addr_reg;
        K_WA0:   fld_val = wa_reg[0];
        K_WA1:   fld_val = wa_reg[1];
        K_WA2:   fld_val = wa_reg[2];
        default: fld_val = 16'h0000;
      endcase
  end

  // capture read selection for the answer cycle
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      rd_ok_reg  <= 1'b0;
      rd_mem_reg <= 1'b0;
      rd_vld_reg <= 1'b0;
      rd_fld_reg <= 16'h0000;
    end
    else
    begin
      rd_ok_reg  <= rd_ok;
      rd_mem_reg <= mem_acc;
      rd_vld_reg <= valid_reg[mem_idx];
      rd_fld_reg <= fld_val;
    end
  end

  assign mgmt_rack_o  = rd_ok_reg;
  assign mgmt_rdata_o = !rd_ok_reg ? 16'h0000
                      : rd_mem_reg ? (rd_vld_reg ? mem_q : 16'h0000)
                      : rd_fld_reg;

endmodule // cpm_top

// >>> verif/cpm_top_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// port checks for the management block
// ------------------------------------------------------------------
module cpm_top_checker import cpm_pkg::*; #(
  parameter logic [4:0] PHY_ADDR = 5'h00
) (
  input wire logic          ref_clk_i,
  input wire logic          rstn_i,
  input wire logic [1:0]    mgmt_ctrl_id_i,
  input wire logic [4:0]    mgmt_phy_addr_i,
  input wire logic          mgmt_re_i,
  input wire logic [15:0]   mgmt_rdata_o,
  input wire logic          mgmt_rack_o,
  input wire cpm_line_cfg_s line_cfg_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  a_read_answer : assert property (
    mgmt_re_i && mgmt_ctrl_id_i == 2'h0 && mgmt_phy_addr_i == PHY_ADDR
    |=> mgmt_rack_o) else $error("read left unanswered");
  a_bad_ctrl : assert property (
    mgmt_re_i && mgmt_ctrl_id_i != 2'h0 |=> !mgmt_rack_o)
    else $error("read answered on other controller");
  a_bad_addr : assert property (
    mgmt_re_i && mgmt_phy_addr_i != PHY_ADDR |=> !mgmt_rack_o)
    else $error("read answered on foreign address");
  a_rack_cause : assert property (
    mgmt_rack_o |-> $past(mgmt_re_i) && $past(mgmt_ctrl_id_i) == 2'h0)
    else $error("answer without request");
  a_rdata_idle : assert property (
    !mgmt_rack_o |-> mgmt_rdata_o == 16'h0000)
    else $error("read data outside answer");
  a_cfg_after_rst : assert property (
    $rose(rstn_i) |=> line_cfg_o.neg_run && line_cfg_o.pol_fix_en)
    else $error("config not default after reset");
  a_gig_needs_neg : assert property (
    line_cfg_o.speed == SPD_1000 |-> line_cfg_o.neg_run
    || line_cfg_o.gig_test) else $error("gigabit without negotiation");
  a_test_gig : assert property (
    line_cfg_o.gig_test |-> line_cfg_o.speed == SPD_1000
    && !line_cfg_o.neg_run) else $error("test mode not forced gigabit");
  a_lpi_speed : assert property (
    line_cfg_o.lpi_en |-> line_cfg_o.speed != SPD_10)
    else $error("idle cycling at 10M");
endmodule // cpm_top_checker

bind cpm_top cpm_top_checker #(.PHY_ADDR(PHY_ADDR)) u_chk (
  .ref_clk_i       (ref_clk_i),
  .rstn_i          (rstn_i),
  .mgmt_ctrl_id_i  (mgmt_ctrl_id_i),
  .mgmt_phy_addr_i (mgmt_phy_addr_i),
  .mgmt_re_i       (mgmt_re_i),
  .mgmt_rdata_o    (mgmt_rdata_o),
  .mgmt_rack_o     (mgmt_rack_o),
  .line_cfg_o      (line_cfg_o)
);

// >>> verif/cpm_line_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// line side stand-in, events: link, wake, gig fail, partner gig
// ------------------------------------------------------------------
module cpm_line_model import cpm_pkg::*; (
  input  wire logic          ref_clk_i,
  input  wire logic          rstn_i,
  input  wire cpm_line_cfg_s cfg_i,
  input  wire logic [3:0]    ev_i,
  output cpm_line_stat_s     stat_o
);
  // status answers one cycle after config and events
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
      stat_o <= '0;
    else
    begin
      stat_o.link_up      <= ev_i[0];
      stat_o.wake_pkt     <= ev_i[1];
      stat_o.gig_fail     <= ev_i[2];
      stat_o.partner_gig  <= ev_i[3];
      stat_o.partner_neg  <= cfg_i.neg_run;
      stat_o.pd_speed     <= 2'h1;
      stat_o.res_speed    <= cfg_i.speed;
      stat_o.res_duplex   <= cfg_i.duplex;
      stat_o.res_master   <= cfg_i.master;
      stat_o.mdix_seen    <= cfg_i.mdix;
      stat_o.cd_swap_seen <= cfg_i.cd_swap;
      stat_o.pol_inv      <= cfg_i.pol_fix_en ? 4'h5 : 4'h0;
      stat_o.tx_idle      <= ev_i[0];
    end
  end
endmodule // cpm_line_model

// >>> verif/cpm_top_tb_top.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// self-checking bench for the management block
// ------------------------------------------------------------------
module cpm_top_tb_top import cpm_pkg::*;;
  logic           clk, rstn, we, re, rack, ack;
  logic [1:0]     id;
  logic [4:0]     pa, ra;
  logic [15:0]    wd, rdata, got;
  logic [3:0]     ev;
  logic [47:0]    sta;
  logic [31:0]    rnd;
  cpm_line_stat_s stat;
  cpm_line_cfg_s  cfg;
  int             n_mismatch, n_compared, cyc, pg;
  logic [15:0]    mdl [int];
  logic [15:0]    pgs [4] = '{16'h0000, PAGE_EXT1, PAGE_EXT2, PAGE_GP};
  logic [4:0]     ads [3] = '{5'h05, 5'h1D, 5'h1E};

  cpm_top u_dut (.ref_clk_i(clk), .rstn_i(rstn), .mgmt_ctrl_id_i(id),
    .mgmt_phy_addr_i(pa), .mgmt_reg_addr_i(ra), .mgmt_wdata_i(wd),
    .mgmt_we_i(we), .mgmt_re_i(re), .mgmt_rdata_o(rdata),
    .mgmt_rack_o(rack), .line_stat_i(stat), .line_cfg_o(cfg),
    .wake_station_address_o(sta));
  cpm_line_model u_line (.ref_clk_i(clk), .rstn_i(rstn), .cfg_i(cfg),
    .ev_i(ev), .stat_o(stat));

  // clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // model, bus tasks and compares
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int key(input logic [4:0] a);
    if (pg == 16) return 96 + a;
    if (a < 16 || a == 31 || (pg != 1 && pg != 2)) return a;
    return pg * 32 + a;
  endfunction
  function automatic logic [15:0] mdlv(input logic [4:0] a);
    return mdl.exists(key(a)) ? mdl[key(a)] : 16'h0000;
  endfunction
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    we <= 1'b1;
    ra <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
    if (id == 2'h0 && (pa == 5'h00 || mdl[22][0] === 1'b1))
      if (a == 5'h1F) pg = d; else mdl[key(a)] = d;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    re <= 1'b1;
    ra <= a;
    @(posedge clk);
    re <= 1'b0;
    #1;
    got = rdata;
    ack = rack;
  endtask
  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmpb(input logic g, input logic e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] e);
    rd(a);
    cmp16(got, e);
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
    repeat (3) tick();
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {we, re, id, pa, ra, wd, ev} = '0;
    rstn = 1'b0;
    rnd = 32'h0000003D;
    mdl[22] = 16'h0002;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rdc(5'h00, 16'h1140);
    rdc(5'h16, 16'h0002);
    cmpb(cfg.pol_fix_en, 1'b1);
    cmpb(cfg.adv_gig, 1'b1);
    $display("test reset done");
    // random words in every page, then read back
    for (int r = 0; r < 2; r++)
      for (int p = 0; p < 4; p++)
      begin
        wr(5'h1F, pgs[p]);
        for (int i = 0; i < 3; i++)
        begin
          rnd = xs(rnd);
          if (r == 0) wr(ads[i], rnd[15:0]); else rdc(ads[i], mdlv(ads[i]));
        end
      end
    wr(5'h1F, 16'h0000);
    $display("test pages done");
    // refused accesses and all-address writes
    id <= 2'h1;
    rd(5'h1D);
    cmpb(ack, 1'b0);
    id <= 2'h0;
    pa <= 5'h03;
    wr(5'h1D, 16'h1234);
    pa <= 5'h00;
    rdc(5'h1D, mdlv(5'h1D));
    wr(5'h16, 16'h0003);
    pa <= 5'h03;
    wr(5'h1D, 16'hA5A5);
    rd(5'h1D);
    cmpb(ack, 1'b0);
    pa <= 5'h00;
    rdc(5'h1D, 16'hA5A5);
    $display("test address done");
    // clause 45 window
    wr(5'h0D, 16'h0000);
    wr(5'h0E, 16'h0003);
    wr(5'h0D, 16'h4000);
    wr(5'h0E, 16'h5AC3);
    wr(5'h0D, 16'h0000);
    rdc(5'h0E, 16'h0003);
    wr(5'h0D, 16'h4000);
    rdc(5'h0E, 16'h5AC3);
    // forced speeds, test mode and low amplitude
    wr(5'h00, 16'h2100);
    tick();
    cmpb(cfg.neg_run, 1'b0);
    cmpb(cfg.speed == 2'h1, 1'b1);
    wr(5'h1F, PAGE_EXT2);
    wr(5'h11, 16'h0020);
    tick();
    cmpb(cfg.gig_test, 1'b1);
    wr(5'h00, 16'h0100);
    wr(5'h11, 16'h0010);
    tick();
    cmpb(cfg.low_amp_10m, 1'b1);
    cmpb(cfg.gig_test, 1'b0);
    // station address words
    wr(5'h17, 16'h3333);
    wr(5'h15, 16'h1111);
    wr(5'h16, 16'h2222);
    cmp16(sta[47:32], 16'h3333);
    cmp16(sta[15:0], 16'h1111);
    // bypass, manual pairs and fallback
    wr(5'h1F, PAGE_EXT1);
    wr(5'h17, 16'h0008);
    tick();
    cmpb(cfg.mdix, 1'b0);
    wr(5'h17, 16'h000C);
    tick();
    cmpb(cfg.mdix, 1'b1);
    cmpb(cfg.cd_swap, 1'b0);
    wr(5'h00, 16'h1140);
    wr(5'h14, 16'h0014);
    repeat (2) pulse(2);
    cmpb(cfg.adv_gig, 1'b1);
    pulse(2);
    cmpb(cfg.adv_gig, 1'b0);
    pulse(3);
    cmpb(cfg.adv_gig, 1'b1);
    wr(5'h1F, 16'h0000);
    wr(5'h12, 16'h0010);
    tick();
    cmpb(cfg.pol_fix_en, 1'b0);
    $display("test line done");
    // wake pending set, read and cleared
    ev[0] <= 1'b1;
    wr(5'h19, 16'h0040);
    pulse(1);
    cmpb(cfg.wake_irq, 1'b1);
    rdc(5'h1A, 16'h0040);
    rdc(5'h1A, 16'h0000);
    // soft reset with and without retention, then hardware reset
    wr(5'h00, 16'h9140);
    repeat (2) tick();
    rdc(5'h1D, 16'h0000);
    rdc(5'h16, 16'h0003);
    cmpb(cfg.pol_fix_en, 1'b1);
    wr(5'h16, 16'h0001);
    wr(5'h00, 16'h9140);
    repeat (2) tick();
    rdc(5'h16, 16'h0002);
    wr(5'h16, 16'h0003);
    wr(5'h1F, PAGE_GP);
    rdc(5'h05, 16'h0000);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdc(5'h16, 16'h0002);
    $display("test resets done");
    close_out();
  end
endmodule // cpm_top_tb_top
